// file: include/mtb_pkg.sv
// constants shared by the trace buffer design files
package mtb_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STAT_W     = 16;
  localparam int unsigned TIME_W     = 32;
  localparam int unsigned MAX_BLOCKS = 30000;
  localparam int unsigned IDX_W      = 15;
  localparam int unsigned ACC_W      = 48;
  localparam int unsigned SQ_W       = 80;
  localparam int unsigned ITEM_W     = 5 * DATA_W + TIME_W + STAT_W;
  localparam int unsigned VOLTAGE_RESULT_LSB   = 0;
  localparam int unsigned CURRENT_RESULT_LSB   = 32;
  localparam int unsigned RES_LSB    = 64;
  localparam int unsigned RTV_LSB    = 96;
  localparam int unsigned SRC_LSB    = 128;
  localparam int unsigned TIME_LSB   = 160;
  localparam int unsigned STAT_LSB   = 192;
  localparam logic [IDX_W-1:0] CNT_RESET  = 15'h0000;
  localparam logic [IDX_W-1:0] SIZE_RESET = 15'h7530;
  localparam logic [TIME_W-1:0] TIME_RESET = 32'h0000_0000;
  localparam logic [2:0] SEL_VOLTAGE_RESULT = 3'h0;
  localparam logic [2:0] SEL_CURRENT_RESULT = 3'h1;
  localparam logic [2:0] SEL_RES  = 3'h2;
  localparam logic [2:0] SEL_RTV  = 3'h3;
  localparam logic [2:0] SEL_SRC  = 3'h4;
endpackage

// file: core/mtb_skid.sv
// two-entry valid/ready buffer in front of the trace store
`timescale 1ns/10ps
module mtb_skid #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic             rd_reg, rd_next, wr_reg, wr_next;
  logic [1:0]       cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    rd_next  = rd_reg;
    wr_next  = wr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next          = ~wr_reg;
    end
    if (pop) begin
      rd_next = ~rd_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

  a_skid_no_overflow : assert property (@(posedge clk_sys) disable iff (srst)
    cnt_reg != 2'h3) else $error("skid buffer count out of range");
endmodule // mtb_skid

// file: core/mtb_trace_buffer.sv
// per-channel measurement trace buffer with statistics and readout
`timescale 1ns/10ps
module mtb_trace_buffer (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic                        trig_pulse,
  input  wire logic                        feed_enable,
  input  wire logic [mtb_pkg::IDX_W-1:0]   size_limit,
  input  wire logic                        clear_req,
  input  wire logic                        blk_valid,
  output logic                             blk_ready,
  input  wire logic [mtb_pkg::DATA_W-1:0]  voltage_result,
  input  wire logic [mtb_pkg::DATA_W-1:0]  current_result,
  input  wire logic [mtb_pkg::DATA_W-1:0]  resistance_result,
  input  wire logic [mtb_pkg::DATA_W-1:0]  remote_transient_voltage_result,
  input  wire logic [mtb_pkg::DATA_W-1:0]  source_output_value,
  input  wire logic [mtb_pkg::STAT_W-1:0]  status_word,
  input  wire logic                        rd_req,
  input  wire logic [mtb_pkg::IDX_W-1:0]   rd_index,
  output logic                             rd_valid,
  output logic [mtb_pkg::ITEM_W-1:0]       rd_block,
  input  wire logic [2:0]                  stat_sel,
  output logic                             stat_valid,
  output logic signed [mtb_pkg::DATA_W-1:0] stat_mean,
  output logic [mtb_pkg::DATA_W-1:0]       standard_deviation,
  output logic signed [mtb_pkg::DATA_W-1:0] stat_min,
  output logic signed [mtb_pkg::DATA_W-1:0] stat_max,
  output logic [mtb_pkg::DATA_W-1:0]       peak_to_peak,
  output logic                             full_flag,
  output logic [mtb_pkg::IDX_W-1:0]        fill_count
);
  localparam int unsigned DW = mtb_pkg::DATA_W;
  localparam int unsigned AW = mtb_pkg::ACC_W;
  localparam int unsigned SW = mtb_pkg::SQ_W;

  // block store, flip-flops addressed by index
  logic [mtb_pkg::ITEM_W-1:0] store_reg [mtb_pkg::MAX_BLOCKS];

  logic [mtb_pkg::TIME_W-1:0] now_reg, now_next;
  logic [mtb_pkg::TIME_W-1:0] trig_time_reg, trig_time_next;
  logic [mtb_pkg::IDX_W-1:0]  cnt_reg, cnt_next;
  logic                       full_reg, full_next;
  logic [mtb_pkg::IDX_W-1:0]  limit;
  logic [mtb_pkg::ITEM_W-1:0] in_item, sk_data;
  logic                       sk_valid, sk_ready, wr_en;

  // active threshold: configured size, clipped to capacity, never zero
  always_comb begin
    limit = size_limit;
    if (size_limit == mtb_pkg::CNT_RESET || size_limit > mtb_pkg::SIZE_RESET) begin
      limit = mtb_pkg::SIZE_RESET;
    end
  end

  always_comb begin
    in_item = '0;
    in_item[mtb_pkg::VOLTAGE_RESULT_LSB +: DW] = voltage_result;
    in_item[mtb_pkg::CURRENT_RESULT_LSB +: DW] = current_result;
    in_item[mtb_pkg::RES_LSB  +: DW] = resistance_result;
    in_item[mtb_pkg::RTV_LSB  +: DW] = remote_transient_voltage_result;
    in_item[mtb_pkg::SRC_LSB  +: DW] = source_output_value;
    in_item[mtb_pkg::TIME_LSB +: mtb_pkg::TIME_W] = trig_time_reg;
    in_item[mtb_pkg::STAT_LSB +: mtb_pkg::STAT_W] = status_word;
  end

  mtb_skid #(
    .WIDTH(mtb_pkg::ITEM_W)
  ) u_skid (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .in_valid (blk_valid),
    .in_ready (blk_ready),
    .in_data  (in_item),
    .out_valid(sk_valid),
    .out_ready(sk_ready),
    .out_data (sk_data)
  );

  // drained blocks are stored while collecting, dropped when full or fed off
  assign sk_ready = 1'b1;
  assign wr_en    = sk_valid && feed_enable && !full_reg;

  always_comb begin
    now_next       = now_reg + 32'h0000_0001;
    trig_time_next = trig_time_reg;
    cnt_next       = cnt_reg;
    full_next      = full_reg;
    if (trig_pulse) begin
      trig_time_next = now_reg; // trigger only latches time
    end
    if (clear_req) begin
      cnt_next  = mtb_pkg::CNT_RESET;
      full_next = 1'b0;
    end else if (wr_en) begin
      cnt_next  = cnt_reg + 15'h0001;
      full_next = (cnt_next >= limit);
    end else if (cnt_reg >= limit) begin
      full_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      now_reg       <= mtb_pkg::TIME_RESET;
      trig_time_reg <= mtb_pkg::TIME_RESET;
      cnt_reg       <= mtb_pkg::CNT_RESET;
      full_reg      <= 1'b0;
    end else begin
      now_reg       <= now_next;
      trig_time_reg <= trig_time_next;
      cnt_reg       <= cnt_next;
      full_reg      <= full_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en && !clear_req) begin
      store_reg[cnt_reg] <= sk_data;
    end
  end

  assign full_flag  = full_reg;
  assign fill_count = cnt_reg;

  // readout by index, does not touch store or count
  logic                       rd_valid_reg, rd_valid_next;
  logic [mtb_pkg::ITEM_W-1:0] rd_block_reg, rd_block_next;

  always_comb begin
    rd_valid_next = rd_req;
    rd_block_next = rd_block_reg;
    if (rd_req) begin
      rd_block_next = (rd_index < cnt_reg) ? store_reg[rd_index] : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_valid_reg <= 1'b0;
      rd_block_reg <= '0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_block_reg <= rd_block_next;
    end
  end

  assign rd_valid = rd_valid_reg;
  assign rd_block = rd_block_reg;

  // running statistics of the selected item over stored blocks
  logic signed [DW-1:0] sel_val;
  logic signed [AW-1:0] sum_reg, sum_next;
  logic [SW-1:0]        sq_reg, sq_next;
  logic signed [DW-1:0] min_reg, min_next, max_reg, max_next;
  logic [2:0]           sel_reg, sel_next;

  always_comb begin
    unique case (stat_sel)
      mtb_pkg::SEL_CURRENT_RESULT: sel_val = sk_data[mtb_pkg::CURRENT_RESULT_LSB +: DW];
      mtb_pkg::SEL_RES:  sel_val = sk_data[mtb_pkg::RES_LSB +: DW];
      mtb_pkg::SEL_RTV:  sel_val = sk_data[mtb_pkg::RTV_LSB +: DW];
      mtb_pkg::SEL_SRC:  sel_val = sk_data[mtb_pkg::SRC_LSB +: DW];
      default:           sel_val = sk_data[mtb_pkg::VOLTAGE_RESULT_LSB +: DW];
    endcase
  end

  always_comb begin
    sum_next = sum_reg;
    sq_next  = sq_reg;
    min_next = min_reg;
    max_next = max_reg;
    sel_next = stat_sel;
    if (clear_req || stat_sel != sel_reg) begin
      sum_next = '0;
      sq_next  = '0;
      min_next = '0;
      max_next = '0;
    end else if (wr_en) begin
      sum_next = sum_reg + AW'(sel_val);
      sq_next  = sq_reg + SW'($unsigned(64'(sel_val) * 64'(sel_val)));
      if (cnt_reg == mtb_pkg::CNT_RESET || sel_val < min_reg) begin
        min_next = sel_val;
      end
      if (cnt_reg == mtb_pkg::CNT_RESET || sel_val > max_reg) begin
        max_next = sel_val;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sum_reg <= '0;
      sq_reg  <= '0;
      min_reg <= '0;
      max_reg <= '0;
      sel_reg <= mtb_pkg::SEL_VOLTAGE_RESULT;
    end else begin
      sum_reg <= sum_next;
      sq_reg  <= sq_next;
      min_reg <= min_next;
      max_reg <= max_next;
      sel_reg <= sel_next;
    end
  end

  // mean and variance by division; deviation by integer square root
  logic signed [AW-1:0] mean_w;
  logic [SW-1:0]        var_w;
  logic [DW-1:0]        root_w;
  logic [SW-1:0]        ms_w;
  logic [SW-1:0]        msq_w;

  always_comb begin
    mean_w = '0;
    ms_w   = '0;
    msq_w  = '0;
    var_w  = '0;
    if (cnt_reg != mtb_pkg::CNT_RESET) begin
      mean_w = sum_reg / $signed({1'b0, cnt_reg});
      ms_w   = sq_reg / SW'(cnt_reg);
      // a negative mean must square as signed, like the stored squares
      msq_w  = SW'($unsigned(64'($signed(mean_w[DW-1:0])) * 64'($signed(mean_w[DW-1:0]))));
      var_w  = (ms_w < msq_w) ? '0 : ms_w - msq_w;
    end
  end

  always_comb begin
    logic [SW-1:0] trial;
    trial  = '0;
    root_w = '0;
    for (int b = DW - 1; b >= 0; b--) begin
      trial = SW'(root_w | (DW'(1) << b));
      if (trial * trial <= var_w) begin
        root_w = trial[DW-1:0];
      end
    end
  end

  logic                 sv_reg, sv_next;
  logic signed [DW-1:0] mean_reg, mean_next;
  logic [DW-1:0]        sd_reg, sd_next;

  always_comb begin
    sv_next   = (cnt_reg != mtb_pkg::CNT_RESET);
    mean_next = mean_w[DW-1:0];
    sd_next   = root_w;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sv_reg   <= 1'b0;
      mean_reg <= '0;
      sd_reg   <= '0;
    end else begin
      sv_reg   <= sv_next;
      mean_reg <= mean_next;
      sd_reg   <= sd_next;
    end
  end

  assign stat_valid         = sv_reg;
  assign stat_mean          = mean_reg;
  assign standard_deviation = sd_reg;
  assign stat_min           = min_reg;
  assign stat_max           = max_reg;
  assign peak_to_peak       = DW'(max_reg - min_reg);

  sequence s_full_seen;
    full_reg && !clear_req;
  endsequence

  a_full_holds_count : assert property (@(posedge clk_sys) disable iff (srst)
    s_full_seen |=> $stable(cnt_reg)) else $error("count moved while full");
  a_store_advances : assert property (@(posedge clk_sys) disable iff (srst)
    wr_en && !clear_req |=> cnt_reg == $past(cnt_reg) + 15'h0001) else $error("bad append");
  a_no_store_full : assert property (@(posedge clk_sys) disable iff (srst)
    full_reg |-> !wr_en) else $error("write while full");
  a_full_at_limit : assert property (@(posedge clk_sys) disable iff (srst)
    $rose(full_reg) |-> cnt_reg >= $past(limit)) else $error("early full");
  a_feed_gates : assert property (@(posedge clk_sys) disable iff (srst)
    !feed_enable && !clear_req |=> cnt_reg == $past(cnt_reg)) else $error("store when off");
  a_trig_keeps : assert property (@(posedge clk_sys) disable iff (srst)
    trig_pulse && !wr_en && !clear_req |=> $stable(cnt_reg)) else $error("trigger moved");
  a_trig_stamp : assert property (@(posedge clk_sys) disable iff (srst)
    trig_pulse |=> trig_time_reg == $past(now_reg)) else $error("stamp wrong");
  a_reset_empty : assert property (@(posedge clk_sys)
    srst |=> cnt_reg == 15'h0000 && !full_reg) else $error("reset not empty");
  a_stat_order : assert property (@(posedge clk_sys) disable iff (srst)
    stat_valid |-> stat_min <= stat_max) else $error("min above max");
  a_read_answer : assert property (@(posedge clk_sys) disable iff (srst)
    rd_req |=> rd_valid) else $error("read not answered");
endmodule // mtb_trace_buffer

// file: testbench/mtb_meas_src.sv
// measurement engine model: sends queued result blocks with random stalls
`timescale 1ns/10ps
module mtb_meas_src (
  input  wire logic    clk_sys,
  input  wire logic    srst,
  input  wire logic    blk_ready,
  output logic         blk_valid,
  output logic [175:0] blk_items
);
  logic [175:0] q[$];
  logic         took = 1'b0;

  initial begin
    blk_valid = 1'b0;
    blk_items = '0;
  end

  // acceptance is judged on the values before the edge
  always @(posedge clk_sys) begin
    took = blk_valid & blk_ready & ~srst;
  end

  always @(negedge clk_sys) begin
    if (took) begin
      void'(q.pop_front());
    end
    if (took || !blk_valid) begin
      if (q.size() != 0 && $urandom_range(2) != 0) begin
        blk_valid = 1'b1;
        blk_items = q[0];
      end else if (blk_valid) begin
        blk_valid = 1'b0;
        // released lines never keep showing the last word
        blk_items = ~blk_items;
      end
    end
  end
endmodule // mtb_meas_src

// file: testbench/measurement_trace_buffer_tb_top.sv
// self-checking bench for the trace buffer
`timescale 1ns/10ps
module measurement_trace_buffer_tb_top;
  logic                       clk_sys;
  logic                       srst;
  logic                       trig_pulse;
  logic                       feed_enable;
  logic [14:0]                size_limit;
  logic                       clear_req;
  logic                       blk_valid;
  logic                       blk_ready;
  logic [175:0]               items;
  logic                       rd_req;
  logic [14:0]                rd_index;
  logic                       rd_valid;
  logic [207:0]               rd_block;
  logic [2:0]                 stat_sel;
  logic                       stat_valid;
  logic signed [31:0]         stat_mean;
  logic [31:0]                standard_deviation;
  logic signed [31:0]         stat_min;
  logic signed [31:0]         stat_max;
  logic [31:0]                peak_to_peak;
  logic                       full_flag;
  logic [14:0]                fill_count;
  int                         errors = 0;
  int                         compares = 0;
  int                         cyc = 0;
  int                         mcnt;
  int                         mlim;
  int                         t1;
  int                         t2;
  logic [207:0]               store[$];
  logic [207:0]               exp_q[$];
  logic [31:0]                tq[$];
  logic signed [31:0]         a;
  logic signed [31:0]         k;

  mtb_meas_src u_src (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .blk_ready(blk_ready),
    .blk_valid(blk_valid),
    .blk_items(items)
  );

  mtb_trace_buffer u_dut (
    .clk_sys                        (clk_sys),
    .srst                           (srst),
    .trig_pulse                     (trig_pulse),
    .feed_enable                    (feed_enable),
    .size_limit                     (size_limit),
    .clear_req                      (clear_req),
    .blk_valid                      (blk_valid),
    .blk_ready                      (blk_ready),
    .voltage_result                 (items[31:0]),
    .current_result                 (items[63:32]),
    .resistance_result              (items[95:64]),
    .remote_transient_voltage_result(items[127:96]),
    .source_output_value            (items[159:128]),
    .status_word                    (items[175:160]),
    .rd_req                         (rd_req),
    .rd_index                       (rd_index),
    .rd_valid                       (rd_valid),
    .rd_block                       (rd_block),
    .stat_sel                       (stat_sel),
    .stat_valid                     (stat_valid),
    .stat_mean                      (stat_mean),
    .standard_deviation             (standard_deviation),
    .stat_min                       (stat_min),
    .stat_max                       (stat_max),
    .peak_to_peak                   (peak_to_peak),
    .full_flag                      (full_flag),
    .fill_count                     (fill_count)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc++;

  task automatic chk_blk(input logic [207:0] got, input logic [207:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // read watcher: time item kept aside for the timestamp check
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1 && exp_q.size() != 0) begin
      chk_blk(rd_block & ~(208'hffffffff << 160), exp_q.pop_front());
      tq.push_back(rd_block[191:160]);
    end
  end

  // queue one block with item sel forced to v; model decides if it is kept
  task automatic send(input logic [2:0] sel, input logic signed [31:0] v);
    logic [175:0] b;
    b = 176'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
    b[sel*32 +: 32] = v;
    u_src.q.push_back(b);
    if (feed_enable && mcnt < mlim) begin
      store.push_back({b[175:160], 32'h0, b[159:0]});
      mcnt++;
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((u_src.q.size() != 0 || blk_valid) && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic rd(input int idx);
    exp_q.push_back(idx < mcnt ? store[idx] : 208'h0);
    rd_req = 1'b1;
    rd_index = idx[14:0];
    @(negedge clk_sys);
    rd_req = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic trig(output int t);
    trig_pulse = 1'b1;
    t = cyc;
    @(negedge clk_sys);
    trig_pulse = 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    trig_pulse = 1'b0;
    feed_enable = 1'b1;
    size_limit = 15'h0004;
    clear_req = 1'b0;
    rd_req = 1'b0;
    rd_index = 15'h0000;
    stat_sel = mtb_pkg::SEL_VOLTAGE_RESULT;
    mcnt = 0;
    mlim = 4;
    void'($urandom(87993));
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    chk_val({17'h0, fill_count}, 32'h0);
    chk_val({31'h0, full_flag}, 32'h0);
    // small limit: fill, re-trigger, overfill
    trig(t1);
    repeat (5) @(negedge clk_sys);
    for (int i = 0; i < 3; i++) send(3'h0, $urandom);
    drain();
    chk_val({17'h0, fill_count}, 32'h3);
    chk_val({31'h0, full_flag}, 32'h0);
    trig(t2);
    repeat (7) @(negedge clk_sys);
    chk_val({17'h0, fill_count}, 32'h3);
    for (int i = 0; i < 3; i++) send(3'h0, $urandom);
    drain();
    chk_val({17'h0, fill_count}, 32'h4);
    chk_val({31'h0, full_flag}, 32'h1);
    for (int i = 0; i < 5; i++) rd(i);
    repeat (3) @(negedge clk_sys);
    chk_val(tq[1] - tq[0], 32'h0);
    chk_val(tq[3] - tq[0], t2 - t1);
    chk_val({17'h0, fill_count}, 32'h4);
    // statistics per item, plus a block refused with feed off
    size_limit = 15'h0000;
    mlim = 30000;
    for (int s = 0; s < 5; s++) begin
      stat_sel = s[2:0];
      clear_req = 1'b1;
      @(negedge clk_sys);
      clear_req = 1'b0;
      store.delete();
      mcnt = 0;
      a = $signed($urandom) >>> 4;
      k = $urandom_range(1000, 1);
      send(s[2:0], a + 2 * k);
      send(s[2:0], a);
      drain();
      feed_enable = 1'b0;
      send(s[2:0], 32'h7fff_0000);
      drain();
      feed_enable = 1'b1;
      chk_val({17'h0, fill_count}, 32'h2);
      chk_val({31'h0, stat_valid}, 32'h1);
      chk_val(stat_min, a);
      chk_val(stat_max, a + 2 * k);
      chk_val(peak_to_peak, 2 * k);
      chk_val(stat_mean, a + k);
      chk_val(standard_deviation, k);
      rd(1);
      rd(2);
    end
    repeat (3) @(negedge clk_sys);
    test_done();
  end
endmodule // measurement_trace_buffer_tb_top
